// ---- src/dpram_host_pkg.sv ----
package dpram_host_pkg;
	// ==========================================
	// geometry of the far device
	localparam int ADDR_W = 14;
	localparam int DATA_W = 18;
	localparam int TOKEN_ADDR_W = 3;
	localparam logic [13:0] MAILBOX_RIGHT = 14'h3fff;
	localparam logic [13:0] MAILBOX_LEFT = 14'h3ffe;

	// ==========================================
	// own register map, byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// ctrl fields
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LO = 1;
	localparam int CTRL_UPPER = 3;
	localparam int CTRL_LOWER = 4;
	// status fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_LOST = 1;
	localparam int ST_MAILBOX = 2;
	localparam int ST_LOSS_PIN = 3;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0018;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		OP_RAM_READ = 2'b00,
		OP_RAM_WRITE = 2'b01,
		OP_TOKEN_READ = 2'b10,
		OP_TOKEN_WRITE = 2'b11
	} op_t;

	// ==========================================
	// timing, slowest speed grade
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETTLE_NS = 20;
	localparam int PULSE_NS = 15;
	localparam int ACCESS_NS = 20;
	localparam int FLOWTHROUGH_NS = 30;
	localparam int GAP_NS = 10;
	localparam int SYNC_STAGES = 2;

	function automatic int min_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [3:0] SETTLE_CYC = 4'(min_cycles(SETTLE_NS));
	localparam logic [3:0] PULSE_CYC = 4'(min_cycles(PULSE_NS));
	localparam logic [3:0] ACCESS_CYC = 4'(min_cycles(ACCESS_NS));
	localparam logic [3:0] FLOWTHROUGH_CYC =
		4'(min_cycles(FLOWTHROUGH_NS));
	localparam logic [3:0] GAP_CYC = 4'(min_cycles(GAP_NS));
	localparam logic [3:0] SYNC_CYC = 4'(SYNC_STAGES);
endpackage

// ---- src/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// first stage feeds nothing but the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '1;
			q_r <= '1;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule

// ---- src/apb_regs.sv ----
`timescale 1ns/1ps
module apb_regs (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic active,
	input wire logic [31:0] status,
	input wire logic [31:0] rdata,
	output logic start,
	output logic [31:0] ctrl,
	output logic [31:0] addr,
	output logic [31:0] wdata
);
	logic [31:0] ctrl_r, ctrl_nxt, addr_r, addr_nxt, wdata_r, wdata_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic ready_r, ready_nxt, err_r, err_nxt, start_r, start_nxt;
	logic setup, commit, mapped;

	// ==========================================
	// decode
	assign setup = psel && !penable;
	assign commit = psel && penable && ready_r;
	always_comb begin
		case (paddr)
			dpram_host_pkg::REG_CTRL, dpram_host_pkg::REG_ADDR,
			dpram_host_pkg::REG_WDATA, dpram_host_pkg::REG_RDATA,
			dpram_host_pkg::REG_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ==========================================
	// answer is registered, so pready rises in the first access cycle
	always_comb begin
		ready_nxt = setup;
		err_nxt = setup && !mapped;
		prdata_nxt = prdata_r;
		if (setup) begin
			case (paddr)
				dpram_host_pkg::REG_CTRL: prdata_nxt = ctrl_r;
				dpram_host_pkg::REG_ADDR: prdata_nxt = addr_r;
				dpram_host_pkg::REG_WDATA: prdata_nxt = wdata_r;
				dpram_host_pkg::REG_RDATA: prdata_nxt = rdata;
				dpram_host_pkg::REG_STATUS: prdata_nxt = status;
				default: prdata_nxt = dpram_host_pkg::ZERO_WORD;
			endcase
		end
		ctrl_nxt = ctrl_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		start_nxt = 1'b0;
		if (commit && pwrite) begin
			case (paddr)
				dpram_host_pkg::REG_CTRL: begin
					// a go while an operation runs is dropped
					ctrl_nxt = pwdata & ~32'h0000_0001;
					start_nxt = pwdata[dpram_host_pkg::CTRL_GO] && !active;
				end
				dpram_host_pkg::REG_ADDR: addr_nxt = pwdata;
				dpram_host_pkg::REG_WDATA: wdata_nxt = pwdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= dpram_host_pkg::CTRL_RESET;
			addr_r <= dpram_host_pkg::ZERO_WORD;
			wdata_r <= dpram_host_pkg::ZERO_WORD;
			prdata_r <= dpram_host_pkg::ZERO_WORD;
			ready_r <= 1'b0;
			err_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			prdata_r <= prdata_nxt;
			ready_r <= ready_nxt;
			err_r <= err_nxt;
			start_r <= start_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = ready_r;
	assign pslverr = err_r;
	assign start = start_r;
	assign ctrl = ctrl_r;
	assign addr = addr_r;
	assign wdata = wdata_r;
endmodule

// ---- src/dpram_host.sv ----
// How it works
// - direction stays read while address changes
// - read array with select and output enable
// - token read uses token select, not select
// - select stays high through token write/read
// - slave writes wait for loss flag settling
`timescale 1ns/1ps
module dpram_host (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [13:0] addr,
	output logic [17:0] data_o,
	output logic [17:0] data_oe,
	input wire logic [17:0] data_i,
	output logic ce_n,
	output logic rw_n,
	output logic oe_n,
	output logic upper_lane_select_n,
	output logic lower_lane_select_n,
	output logic token_latch_select_n,
	input wire logic loss_n,
	input wire logic mailbox_n
);
	typedef enum logic [6:0] {
		S_IDLE = 7'b000_0001,
		S_ADDR = 7'b000_0010,
		S_SELECT = 7'b000_0100,
		S_PULSE = 7'b000_1000,
		S_END = 7'b001_0000,
		S_SAMPLE = 7'b010_0000,
		S_GAP = 7'b100_0000
	} state_t;

	state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic lost_r, lost_nxt;
	logic [17:0] rd_r, rd_nxt;
	logic [13:0] addr_r, addr_nxt;
	logic [17:0] dout_r, dout_nxt;
	logic drive_r, drive_nxt;
	logic ce_r, ce_nxt, rw_r, rw_nxt, oe_r, oe_nxt;
	logic up_r, up_nxt, lo_r, lo_nxt, tok_r, tok_nxt;
	logic start;
	logic [31:0] ctrl, reg_addr, reg_wdata, status, rdata_word;
	logic [17:0] din_s;
	logic loss_s, mailbox_s;
	dpram_host_pkg::op_t op;
	logic is_token, is_write;

	// ==========================================
	// register file and pin synchronisers
	apb_regs regs (
		.clk(clk),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.active(state_r != S_IDLE),
		.status(status),
		.rdata(rdata_word),
		.start(start),
		.ctrl(ctrl),
		.addr(reg_addr),
		.wdata(reg_wdata)
	);

	pin_sync #(.W(20)) sync_pins (
		.clk(clk),
		.nrst(nrst),
		.d({loss_n, mailbox_n, data_i}),
		.q({loss_s, mailbox_s, din_s})
	);

	assign op = dpram_host_pkg::op_t'(ctrl[dpram_host_pkg::CTRL_OP_LO +: 2]);
	assign is_token = op[1];
	assign is_write = op[0];
	assign rdata_word = {14'h0000, rd_r};
	// mailbox flag of this port shows here; a read of MAILBOX_LEFT is the clear
	always_comb begin
		status = dpram_host_pkg::ZERO_WORD;
		status[dpram_host_pkg::ST_ACTIVE] = (state_r != S_IDLE);
		status[dpram_host_pkg::ST_LOST] = lost_r;
		status[dpram_host_pkg::ST_MAILBOX] = !mailbox_s;
		status[dpram_host_pkg::ST_LOSS_PIN] = !loss_s;
	end

	// ==========================================
	// access sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		lost_nxt = lost_r;
		rd_nxt = rd_r;
		addr_nxt = addr_r;
		dout_nxt = dout_r;
		drive_nxt = drive_r;
		ce_nxt = ce_r;
		rw_nxt = rw_r;
		oe_nxt = oe_r;
		up_nxt = up_r;
		lo_nxt = lo_r;
		tok_nxt = tok_r;
		case (state_r)
			S_IDLE: begin
				if (start) begin
					// address moves only with everything deselected
					rw_nxt = 1'b1;
					if (is_token) begin
						addr_nxt = {11'h000, reg_addr[2:0]};
					end else begin
						addr_nxt = reg_addr[13:0];
					end
					// token write carries the request on bit zero
					dout_nxt = is_token ? {17'h0_0000, reg_wdata[0]} :
						reg_wdata[17:0];
					lost_nxt = 1'b0;
					state_nxt = S_ADDR;
				end
			end
			S_ADDR: begin
				if (is_token) begin
					// chip select held high for the token path
					ce_nxt = 1'b1;
					tok_nxt = 1'b0;
					up_nxt = 1'b1;
					lo_nxt = 1'b1;
				end else begin
					ce_nxt = 1'b0;
					tok_nxt = 1'b1;
					up_nxt = !ctrl[dpram_host_pkg::CTRL_UPPER];
					lo_nxt = !ctrl[dpram_host_pkg::CTRL_LOWER];
				end
				// output enable joins the select for reads only
				oe_nxt = is_write;
				cnt_nxt = is_write ? dpram_host_pkg::SETTLE_CYC :
					dpram_host_pkg::ACCESS_CYC;
				state_nxt = S_SELECT;
			end
			S_SELECT: begin
				if (!is_token && !loss_s) begin
					// arbitration lost: hold off and restart the wait
					lost_nxt = 1'b1;
					cnt_nxt = is_write ? dpram_host_pkg::SETTLE_CYC :
						dpram_host_pkg::FLOWTHROUGH_CYC;
				end else if (cnt_r > 4'h1) begin
					cnt_nxt = cnt_r - 4'h1;
				end else if (is_write) begin
					// output enable already high, so the device stays off the bus
					rw_nxt = 1'b0;
					drive_nxt = 1'b1;
					cnt_nxt = dpram_host_pkg::PULSE_CYC;
					state_nxt = S_PULSE;
				end else begin
					cnt_nxt = dpram_host_pkg::SYNC_CYC;
					state_nxt = S_SAMPLE;
				end
			end
			S_PULSE: begin
				if (cnt_r > 4'h1) begin
					cnt_nxt = cnt_r - 4'h1;
				end else begin
					// rising direction pin stores the data still driven
					rw_nxt = 1'b1;
					state_nxt = S_END;
				end
			end
			S_END: begin
				ce_nxt = 1'b1;
				tok_nxt = 1'b1;
				up_nxt = 1'b1;
				lo_nxt = 1'b1;
				drive_nxt = 1'b0;
				cnt_nxt = dpram_host_pkg::GAP_CYC;
				state_nxt = S_GAP;
			end
			S_SAMPLE: begin
				// pin data needs the synchroniser depth before capture
				if (cnt_r > 4'h1) begin
					cnt_nxt = cnt_r - 4'h1;
				end else begin
					rd_nxt = din_s;
					ce_nxt = 1'b1;
					tok_nxt = 1'b1;
					oe_nxt = 1'b1;
					up_nxt = 1'b1;
					lo_nxt = 1'b1;
					cnt_nxt = dpram_host_pkg::GAP_CYC;
					state_nxt = S_GAP;
				end
			end
			S_GAP: begin
				// deselected gap so a token read-back sees the update
				if (cnt_r > 4'h1) begin
					cnt_nxt = cnt_r - 4'h1;
				end else begin
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_IDLE;
				ce_nxt = 1'b1;
				tok_nxt = 1'b1;
				oe_nxt = 1'b1;
				rw_nxt = 1'b1;
				drive_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= S_IDLE;
			cnt_r <= 4'h0;
			lost_r <= 1'b0;
			rd_r <= 18'h0_0000;
			addr_r <= 14'h0000;
			dout_r <= 18'h0_0000;
			drive_r <= 1'b0;
			ce_r <= 1'b1;
			rw_r <= 1'b1;
			oe_r <= 1'b1;
			up_r <= 1'b1;
			lo_r <= 1'b1;
			tok_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			lost_r <= lost_nxt;
			rd_r <= rd_nxt;
			addr_r <= addr_nxt;
			dout_r <= dout_nxt;
			drive_r <= drive_nxt;
			ce_r <= ce_nxt;
			rw_r <= rw_nxt;
			oe_r <= oe_nxt;
			up_r <= up_nxt;
			lo_r <= lo_nxt;
			tok_r <= tok_nxt;
		end
	end

	assign addr = addr_r;
	assign data_o = dout_r;
	assign data_oe = {18{drive_r}};
	assign ce_n = ce_r;
	assign rw_n = rw_r;
	assign oe_n = oe_r;
	assign upper_lane_select_n = up_r;
	assign lower_lane_select_n = lo_r;
	assign token_latch_select_n = tok_r;
endmodule

// ---- bench/dpram_host_monitor.sv ----
`timescale 1ns/1ps
// ==========
// pin sequence checks
module dpram_host_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [13:0] addr,
	input wire logic [17:0] data_o,
	input wire logic [17:0] data_oe,
	input wire logic ce_n,
	input wire logic rw_n,
	input wire logic oe_n,
	input wire logic upper_lane_select_n,
	input wire logic lower_lane_select_n,
	input wire logic token_latch_select_n,
	input wire logic loss_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_ADDR_READ: assert property (!$stable(addr) |-> rw_n)
		else $error("addr moved in write");
	AST_WR_SEL: assert property (!rw_n |->
		(!ce_n || !token_latch_select_n) && data_oe[0])
		else $error("write without select");
	AST_SEL_FIRST: assert property ($fell(rw_n) |->
		!$past(ce_n) || !$past(token_latch_select_n))
		else $error("select late");
	AST_PULSE: assert property ($fell(rw_n) |->
		!rw_n [*3] ##1 (rw_n && data_oe[0]))
		else $error("write pulse shape");
	AST_DATA_HOLD: assert property (!rw_n |=> $stable(data_o))
		else $error("data moved");
	AST_TOKEN_CE: assert property (!token_latch_select_n |->
		ce_n && upper_lane_select_n && lower_lane_select_n)
		else $error("token with select");
	AST_READ_CE: assert property (!oe_n && token_latch_select_n |->
		!ce_n && data_oe == 18'h0_0000)
		else $error("bad read");
	AST_LOSS_WAIT: assert property (!loss_n [*5] |-> !$fell(rw_n))
		else $error("write under loss");
endmodule
bind dpram_host dpram_host_monitor mon_u (
	.clk(clk),
	.nrst(nrst),
	.addr(addr),
	.data_o(data_o),
	.data_oe(data_oe),
	.ce_n(ce_n),
	.rw_n(rw_n),
	.oe_n(oe_n),
	.upper_lane_select_n(upper_lane_select_n),
	.lower_lane_select_n(lower_lane_select_n),
	.token_latch_select_n(token_latch_select_n),
	.loss_n(loss_n)
);

// ---- bench/dev_model.sv ----
`timescale 1ns/1ps
// ==========
// far device, one port seen
module dev_model (
	input wire logic [13:0] addr,
	input wire logic [17:0] data_o,
	input wire logic [17:0] data_oe,
	output logic [17:0] data_i,
	input wire logic ce_n,
	input wire logic rw_n,
	input wire logic oe_n,
	input wire logic upper_lane_select_n,
	input wire logic lower_lane_select_n,
	input wire logic token_latch_select_n,
	output logic loss_n,
	output logic mailbox_n,
	input wire logic contend,
	input wire logic other_mail
);
	logic [17:0] mem [16384];
	logic [7:0] tok_r = 8'hff;
	logic mb_r = 1'b0;
	logic pend = 1'b0;
	logic wt;
	logic [13:0] wa;
	logic [17:0] wd, wm, m, junk = 18'h2_5a5a;
	wire ram = !ce_n && token_latch_select_n;
	wire tok = ce_n && !token_latch_select_n;
	wire rd = rw_n && !oe_n;
	// released lines toggle so no stale value passes
	always #5 junk = ~junk;
	assign m = {{9{!upper_lane_select_n}}, {9{!lower_lane_select_n}}};
	assign loss_n = !contend;
	assign mailbox_n = !mb_r;
	always @* begin
		if (tok && rd) data_i = {18{tok_r[addr[2:0]]}};
		else if (ram && rd) data_i = (mem[addr] & m) | (junk & ~m);
		else data_i = junk;
	end
	// inline terms: wires may lag this process
	always @(rw_n, ce_n, token_latch_select_n, data_o, data_oe, addr) begin
		if (!rw_n && (!ce_n || !token_latch_select_n) &&
			!contend) begin
			pend = 1'b1;
			wa = addr;
			// an undriven bus stores noise, not the last value
			wd = data_oe[0] ? data_o : junk;
			wt = ce_n;
			wm = {{9{!upper_lane_select_n}}, {9{!lower_lane_select_n}}};
		end else if (pend) begin
			pend = 1'b0;
			if (wt) tok_r[wa[2:0]] = wd[0];
			else mem[wa] = (mem[wa] & ~wm) | (wd & wm);
		end
	end
	// one writer for the flag; a new message wins over a clearing read
	always @* begin
		if (other_mail) begin
			mb_r = 1'b1;
		end else if (ram && rd && !contend &&
			addr == dpram_host_pkg::MAILBOX_LEFT) begin
			mb_r = 1'b0;
		end
	end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	error_cnt++; $display("wrong value t=%0t got %h exp %h", \
	$time, a, e); end end
// ==========
// host bench
module testbench;
	typedef struct packed {
		logic [1:0] op;
		logic [13:0] a;
		logic [17:0] d;
		logic [1:0] ln;
		logic [17:0] e;
	} row_t;
	row_t rows [11] = '{
		'{2'h2, 14'h0005, 18'h0_0000, 2'h3, 18'h3_ffff},
		'{2'h1, 14'h0123, 18'h2_abcd, 2'h3, 18'h0_0000},
		'{2'h0, 14'h0123, 18'h0_0000, 2'h3, 18'h2_abcd},
		'{2'h1, 14'h0123, 18'h3_ffff, 2'h1, 18'h0_0000},
		'{2'h0, 14'h0123, 18'h0_0000, 2'h3, 18'h3_ffcd},
		'{2'h1, 14'h0123, 18'h0_0000, 2'h2, 18'h0_0000},
		'{2'h0, 14'h0123, 18'h0_0000, 2'h3, 18'h3_fe00},
		'{2'h3, 14'h0005, 18'h0_0000, 2'h3, 18'h0_0000},
		'{2'h2, 14'h3ffd, 18'h0_0000, 2'h3, 18'h0_0000},
		'{2'h3, 14'h0005, 18'h0_0001, 2'h3, 18'h0_0000},
		'{2'h2, 14'h0005, 18'h0_0000, 2'h3, 18'h3_ffff}};
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, contend = 1'b0, other_mail = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic pready, pslverr, last_err;
	logic [13:0] addr;
	logic [17:0] data_o, data_oe, data_i;
	logic ce_n, rw_n, oe_n, upper_lane_select_n, lower_lane_select_n;
	logic token_latch_select_n, loss_n, mailbox_n;
	int error_cnt = 0, total_checks = 0;
	always #2.5 clk = ~clk;
	dpram_host dut_u (
		.clk(clk),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.addr(addr),
		.data_o(data_o),
		.data_oe(data_oe),
		.data_i(data_i),
		.ce_n(ce_n),
		.rw_n(rw_n),
		.oe_n(oe_n),
		.upper_lane_select_n(upper_lane_select_n),
		.lower_lane_select_n(lower_lane_select_n),
		.token_latch_select_n(token_latch_select_n),
		.loss_n(loss_n),
		.mailbox_n(mailbox_n)
	);
	dev_model dev_u (
		.addr(addr),
		.data_o(data_o),
		.data_oe(data_oe),
		.data_i(data_i),
		.ce_n(ce_n),
		.rw_n(rw_n),
		.oe_n(oe_n),
		.upper_lane_select_n(upper_lane_select_n),
		.lower_lane_select_n(lower_lane_select_n),
		.token_latch_select_n(token_latch_select_n),
		.loss_n(loss_n),
		.mailbox_n(mailbox_n),
		.contend(contend),
		.other_mail(other_mail)
	);
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic start_op(input logic [1:0] op, input logic [13:0] a,
		input logic [17:0] d, input logic [1:0] ln);
		apb(1'b1, dpram_host_pkg::REG_ADDR, {18'h0_0000, a}, r);
		apb(1'b1, dpram_host_pkg::REG_WDATA, {14'h0000, d}, r);
		apb(1'b1, dpram_host_pkg::REG_CTRL, {27'h000_0000, ln, op, 1'b1}, r);
	endtask
	// wait 4 cycles, then poll: completion time is not fixed
	task automatic finish_op(output logic [31:0] q);
		repeat (4) @(posedge clk);
		do apb(1'b0, dpram_host_pkg::REG_STATUS, 32'h0000_0000, q);
		while (q[0] !== 1'b0);
		apb(1'b0, dpram_host_pkg::REG_RDATA, 32'h0000_0000, q);
	endtask
	task automatic status(output logic [31:0] q);
		apb(1'b0, dpram_host_pkg::REG_STATUS, 32'h0000_0000, q);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		report_and_stop;
	end
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			start_op(rows[i].op, rows[i].a, rows[i].d, rows[i].ln);
			finish_op(r);
			if (!rows[i].op[0]) `CHK(r, {14'h0000, rows[i].e})
		end
		apb(1'b0, 8'h14, 32'h0000_0000, r);
		`CHK({last_err, r}, {1'b1, 32'h0000_0000})
		other_mail <= 1'b1;
		@(posedge clk);
		other_mail <= 1'b0;
		start_op(2'h0, dpram_host_pkg::MAILBOX_RIGHT, 18'h0_0000, 2'h3);
		finish_op(r);
		status(r);
		`CHK(r[2], 1'b1)
		start_op(2'h0, dpram_host_pkg::MAILBOX_LEFT, 18'h0_0000, 2'h3);
		finish_op(r);
		status(r);
		`CHK(r[2], 1'b0)
		contend <= 1'b1;
		start_op(2'h1, 14'h0200, 18'h1_1111, 2'h3);
		repeat (30) @(posedge clk);
		status(r);
		`CHK(r[3:0], 4'hb)
		contend <= 1'b0;
		finish_op(r);
		status(r);
		`CHK(r[1:0], 2'h2)
		start_op(2'h0, 14'h0200, 18'h0_0000, 2'h3);
		finish_op(r);
		`CHK(r, 32'h0001_1111)
		// reset in mid-access: pins must drop back to idle at once
		start_op(2'h1, 14'h0300, 18'h0_5555, 2'h3);
		repeat (3) @(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		`CHK({ce_n, rw_n, oe_n, upper_lane_select_n}, 4'hf)
		`CHK({lower_lane_select_n, token_latch_select_n}, 2'h3)
		`CHK({data_oe, pready, pslverr}, 20'h0_0000)
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, dpram_host_pkg::REG_CTRL, 32'h0000_0000, r);
		`CHK(r, dpram_host_pkg::CTRL_RESET)
		status(r);
		`CHK(r, dpram_host_pkg::ZERO_WORD)
		report_and_stop;
	end
endmodule
